//--- rtl/rsrp_pkg.sv
package rsrp_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int unsigned FRAME_BITS   = 24;
  localparam int unsigned ADDR_BITS    = 3;
  localparam int unsigned REGNUM_BITS  = 5;
  localparam int unsigned DATA_BITS    = 16;
  localparam int unsigned READ_CLOCKS  = 48;
  localparam int unsigned CNT_BITS     = 6;

  // ----------------------------------------------------------------
  // register numbers
  // ----------------------------------------------------------------
  localparam logic [4:0] REG_POWER_EN    = 5'h01;
  localparam logic [4:0] REG_FILTER_CTL  = 5'h02;
  localparam logic [4:0] REG_FILTER_SRC  = 5'h03;
  localparam logic [4:0] REG_GAIN_CTL    = 5'h04;
  localparam logic [4:0] REG_GAIN_LIMIT  = 5'h05;
  localparam logic [4:0] REG_CAL_STATUS  = 5'h06;
  localparam logic [4:0] REG_READ_SELECT = 5'h07;
  localparam logic [4:0] REG_BLOCKER     = 5'h12;
  localparam logic [4:0] REG_PHASE_I     = 5'h14;
  localparam logic [4:0] REG_PHASE_Q     = 5'h15;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_POWER_EN   = 16'hBFBE;
  localparam logic [15:0] RST_FILTER_CTL = 16'hC585;
  localparam logic [15:0] RST_FILTER_SRC = 16'h869F;
  localparam logic [15:0] RST_GAIN_CTL   = 16'h3430;
  localparam logic [15:0] RST_GAIN_LIMIT = 16'hA904;
  localparam logic [15:0] RST_BLOCKER    = 16'hF05C;
  localparam logic [15:0] RST_PHASE      = 16'hF000;
  localparam logic [2:0]  PIN_IDLE       = 3'h2;  // serial clock low, select high, data low

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int unsigned BW_SEL_LSB     = 13;
  localparam int unsigned CAL_OVR_BIT    = 10;
  localparam int unsigned CAL_TRIG_BIT   = 9;
  localparam int unsigned GAIN_SRC_LSB   = 12;
  localparam logic [1:0]  BW_14MHZ       = 2'h0;
  localparam logic [1:0]  BW_28MHZ       = 2'h1;
  localparam logic [1:0]  BW_56MHZ       = 2'h2;
  localparam logic [1:0]  BW_112MHZ      = 2'h3;
  localparam logic [3:0]  GAIN_INTERNAL  = 4'h3;
  localparam logic [3:0]  GAIN_EXTERNAL  = 4'hC;
  localparam logic [7:0]  FACTORY_CAL    = 8'h85;
  localparam logic [1:0]  CAL_STAT_DONE  = 2'h3;

  // ----------------------------------------------------------------
  // decoded frame carried to the register bank
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  chip_addr;
    logic [4:0]  reg_num;
    logic [15:0] data;
  } rsrp_frame_s;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE  = 3'b100
  } rsrp_state_e;

endpackage

//--- rtl/rsrp_port.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - frame is 3-bit chip address, 5-bit register number, 16-bit data
// - serial input is sampled on each of the first 24 rising serial clock edges of a frame
// - after 24 pulses select rises and the 16-bit value is loaded
// - read data is driven on serial output, changing on rising clock
// - nine 16-bit registers, exactly one transferred per operation
// - factory calibration word for 140 MHz centre is recallable
// - filter offers four bandwidths and adjustable centre
// - bandwidth code 00/01/10/11 is 14/28/56/112 MHz, resets to 56
// - centre calibration starts only on 0-to-1 of its trigger bit
// - gain source code 0x3 internal loop, 0xC external voltage
module rsrp_port
  import rsrp_pkg::*;
#(
  parameter logic [2:0] CHIP_ADDR = 3'h0  // arbitrary default
)(
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       serial_clk,
  input  wire logic       frame_select_n,
  input  wire logic       serial_in,
  output logic            serial_out,
  output logic            serial_out_en,
  output logic [15:0]     block_power_enables,
  output logic [1:0]      bandpass_width_select,
  output logic            center_cal_override,
  output logic [7:0]      center_freq_word,
  output logic [7:0]      center_word_active,
  output logic            center_cal_start,
  output logic [3:0]      gain_loop_source,
  output logic            gain_loop_internal,
  output logic            gain_loop_external
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic       sclk_s;
  logic       sel_n_s;
  logic       sdi_s;
  logic       sclk_d_r;
  logic       sclk_rise;

  rsrp_sync #(.WIDTH(3), .RST_VAL(PIN_IDLE)) u_sync (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .async_in ({serial_clk, frame_select_n, serial_in}),
    .sync_out ({sclk_s, sel_n_s, sdi_s})
  );

  // edge detect on the synchronised serial clock
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      sclk_d_r <= 1'b0;
    else
      sclk_d_r <= sclk_s;
  end
  assign sclk_rise = sclk_s & ~sclk_d_r;

  // ----------------------------------------------------------------
  // frame shifter
  // ----------------------------------------------------------------
  rsrp_state_e           state_r;
  logic [CNT_BITS-1:0]   cnt_r;
  logic [FRAME_BITS-1:0] shift_r;
  rsrp_frame_s           frame;
  logic                  commit;

  assign frame = rsrp_frame_s'(shift_r);

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_r <= ST_IDLE;
    else
    begin
      case (state_r)
        ST_IDLE:  if (!sel_n_s) state_r <= ST_SHIFT;
        ST_SHIFT: if (sel_n_s)  state_r <= ST_DONE;
        ST_DONE:  state_r <= ST_IDLE;
        default:  state_r <= ST_IDLE;
      endcase
    end
  end

  // bit counter capped at 48 pulses, msb-first shift capped at one frame
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_r   <= '0;
      shift_r <= '0;
    end
    else if (state_r == ST_IDLE)
      cnt_r <= '0;
    else if (state_r == ST_SHIFT && !sel_n_s && sclk_rise)
    begin
      if (cnt_r < CNT_BITS'(READ_CLOCKS))
        cnt_r <= cnt_r + 6'h01;
      if (cnt_r < CNT_BITS'(FRAME_BITS))
        shift_r <= {shift_r[FRAME_BITS-2:0], sdi_s};
    end
  end

  // load only a full 24-pulse frame addressed to this chip
  assign commit = (state_r == ST_DONE) && (cnt_r == CNT_BITS'(FRAME_BITS))
               && (frame.chip_addr == CHIP_ADDR);

  // ----------------------------------------------------------------
  // register bank
  // ----------------------------------------------------------------
  logic [15:0] filt_ctl_r;
  logic [15:0] filt_src_r;
  logic [15:0] gain_ctl_r;
  logic [15:0] gain_lim_r;
  logic [15:0] block_r;
  logic [15:0] phase_i_r;
  logic [15:0] phase_q_r;
  logic [4:0]  read_sel_r;
  logic [1:0]  cal_stat_r;

  // one register per committed frame
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      block_power_enables <= RST_POWER_EN;
      filt_ctl_r          <= RST_FILTER_CTL;
      filt_src_r          <= RST_FILTER_SRC;
      gain_ctl_r          <= RST_GAIN_CTL;
      gain_lim_r          <= RST_GAIN_LIMIT;
      block_r             <= RST_BLOCKER;
      phase_i_r           <= RST_PHASE;
      phase_q_r           <= RST_PHASE;
      read_sel_r          <= '0;
    end
    else if (commit)
    begin
      case (frame.reg_num)
        REG_POWER_EN:    block_power_enables <= frame.data;
        REG_FILTER_CTL:  filt_ctl_r <= frame.data;
        REG_FILTER_SRC:  filt_src_r <= frame.data;
        REG_GAIN_CTL:    gain_ctl_r <= frame.data;
        REG_GAIN_LIMIT:  gain_lim_r <= frame.data;
        REG_READ_SELECT: read_sel_r <= frame.data[4:0];
        REG_BLOCKER:     block_r    <= frame.data;
        REG_PHASE_I:     phase_i_r  <= frame.data;
        REG_PHASE_Q:     phase_q_r  <= frame.data;
        default:         read_sel_r <= read_sel_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // filter control
  // ----------------------------------------------------------------
  logic cal_trig_d_r;

  assign bandpass_width_select = filt_ctl_r[BW_SEL_LSB +: 2];
  assign center_cal_override   = filt_ctl_r[CAL_OVR_BIT];
  assign center_freq_word      = filt_ctl_r[7:0];

  // centre calibration pulse only on a rising trigger bit
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cal_trig_d_r     <= 1'b0;
      center_cal_start <= 1'b0;
      cal_stat_r       <= CAL_STAT_DONE;
    end
    else
    begin
      cal_trig_d_r     <= filt_ctl_r[CAL_TRIG_BIT];
      center_cal_start <= filt_ctl_r[CAL_TRIG_BIT] & ~cal_trig_d_r;
      if (center_cal_start)
        cal_stat_r <= CAL_STAT_DONE;
    end
  end

  // factory word unless the serial word is forced
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      center_word_active <= FACTORY_CAL;
    else
      center_word_active <= center_cal_override ? center_freq_word : FACTORY_CAL;
  end

  // ----------------------------------------------------------------
  // gain loop source
  // ----------------------------------------------------------------
  assign gain_loop_source   = gain_ctl_r[GAIN_SRC_LSB +: 4];
  assign gain_loop_internal = (gain_loop_source == GAIN_INTERNAL);
  assign gain_loop_external = (gain_loop_source == GAIN_EXTERNAL);

  // ----------------------------------------------------------------
  // read-back
  // ----------------------------------------------------------------
  logic [15:0] rd_word;
  logic [15:0] out_sr_r;

  always_comb
  begin
    case (read_sel_r)
      REG_POWER_EN:   rd_word = block_power_enables;
      REG_FILTER_CTL: rd_word = filt_ctl_r;
      REG_FILTER_SRC: rd_word = filt_src_r;
      REG_GAIN_CTL:   rd_word = gain_ctl_r;
      REG_GAIN_LIMIT: rd_word = gain_lim_r;
      REG_CAL_STATUS: rd_word = {6'h00, cal_stat_r, FACTORY_CAL};
      REG_BLOCKER:    rd_word = block_r;
      REG_PHASE_I:    rd_word = phase_i_r;
      REG_PHASE_Q:    rd_word = phase_q_r;
      default:        rd_word = 16'h0000;
    endcase
  end

  // output shifter: loads on the 24th rising edge, shifts on later rising edges
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_sr_r      <= '0;
      serial_out    <= 1'b0;
      serial_out_en <= 1'b0;
    end
    else if (state_r != ST_SHIFT || sel_n_s)
    begin
      serial_out    <= 1'b0;
      serial_out_en <= 1'b0;
    end
    else if (sclk_rise && cnt_r >= CNT_BITS'(FRAME_BITS - 1) && cnt_r < CNT_BITS'(READ_CLOCKS))
    begin
      if (cnt_r == CNT_BITS'(FRAME_BITS - 1))
      begin
        out_sr_r   <= {rd_word[14:0], 1'b0};
        serial_out <= rd_word[15];
      end
      else
      begin
        out_sr_r   <= {out_sr_r[14:0], 1'b0};
        serial_out <= out_sr_r[15];
      end
      serial_out_en <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  foreign_frame_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_r == ST_DONE && frame.chip_addr != CHIP_ADDR) |=> $stable(block_power_enables))
    else $error("foreign frame changed a register");

  write_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (commit && frame.reg_num == REG_POWER_EN) |=> block_power_enables == $past(frame.data))
    else $error("power register not loaded");

  short_frame_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_r == ST_DONE && cnt_r != CNT_BITS'(FRAME_BITS)) |=> $stable(filt_ctl_r))
    else $error("short frame loaded a register");

  cal_edge_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    center_cal_start |=> !center_cal_start)
    else $error("calibration start held high");

  gain_decode_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !(gain_loop_internal && gain_loop_external))
    else $error("gain source decoded twice");

  out_idle_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    sel_n_s ##1 sel_n_s |-> !serial_out_en)
    else $error("serial output driven outside frame");

  shift_edge_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (state_r == ST_SHIFT && !sclk_rise && !sel_n_s) |=> $stable(shift_r))
    else $error("shift without rising serial clock");

  word_select_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !center_cal_override ##1 !center_cal_override |-> center_word_active == FACTORY_CAL)
    else $error("factory word not selected");
endmodule // rsrp_port
`default_nettype wire

//--- rtl/rsrp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rsrp_sync
  import rsrp_pkg::*;
#(
  parameter int unsigned      WIDTH   = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)(
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;

  // ----------------------------------------------------------------
  // two-flop synchroniser per bit
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge core_clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          // both stages rest at the pin's idle level, so no false edge follows reset
          meta_r[i]   <= RST_VAL[i];
          sync_out[i] <= RST_VAL[i];
        end
        else
        begin
          meta_r[i]   <= async_in[i];
          sync_out[i] <= meta_r[i];
        end
      end
    end
  endgenerate
endmodule // rsrp_sync
`default_nettype wire

//--- testbench/rsrp_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// host serial master model
// ----------------------------------------------------------------
module rsrp_host
  import rsrp_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        serial_out,
  output logic             serial_clk,
  output logic             frame_select_n,
  output logic             serial_in,
  output logic             rd_valid,
  output logic [15:0]      rd_data
);
  // idle pins: clock still low, select high
  initial
  begin
    serial_clk = 1'b0;
    frame_select_n = 1'b1;
    serial_in = 1'b0;
    rd_valid = 1'b0;
    rd_data = 16'h0000;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // one frame msb first, 7 core cycles per half period (below 10 MHz)
  task automatic frame(input logic [23:0] word, input int clocks);
    logic [15:0] got;
    got = 16'h0000;
    @(posedge core_clk);
    frame_select_n <= 1'b0;
    tick(7);
    for (int i = 0; i < clocks; i++)
    begin
      serial_in <= (i < 24) ? word[23-i] : ~serial_in;
      tick(7);
      if (i >= 24 && i <= 39)
        got[39-i] = serial_out;
      serial_clk <= 1'b1;
      tick(7);
      serial_clk <= 1'b0;
    end
    tick(7);
    frame_select_n <= 1'b1;
    serial_in <= ~serial_in;
    tick(10);
    // hand the captured read word to the bench
    if (clocks == 48)
    begin
      rd_data <= got;
      rd_valid <= 1'b1;
      tick(1);
      rd_valid <= 1'b0;
    end
  endtask
endmodule  // rsrp_host
`default_nettype wire

//--- testbench/rsrp_port_test.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// serial register port bench
// ----------------------------------------------------------------
module rsrp_port_test;
  import rsrp_pkg::*;
  logic        core_clk;
  logic        reset_n;
  logic        serial_clk;
  logic        frame_select_n;
  logic        serial_in;
  logic        serial_out;
  logic        serial_out_en;
  logic [15:0] block_power_enables;
  logic [1:0]  bandpass_width_select;
  logic        center_cal_override;
  logic [7:0]  center_freq_word;
  logic [7:0]  center_word_active;
  logic        center_cal_start;
  logic [3:0]  gain_loop_source;
  logic        gain_loop_internal;
  logic        gain_loop_external;
  logic        rd_valid;
  logic [15:0] rd_data;
  logic [15:0] exp_q[$];
  logic [15:0] d;
  logic [15:0] w;
  logic [3:0]  g;
  logic        en_seen;
  logic [4:0]  reg_list [5] = '{REG_FILTER_SRC, REG_GAIN_LIMIT, REG_BLOCKER, REG_PHASE_I, REG_PHASE_Q};
  int          mismatches;
  int          checks_done;
  int          cal_pulses;
  int          seed;

  rsrp_port #(.CHIP_ADDR(3'h0)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .serial_clk(serial_clk),
    .frame_select_n(frame_select_n), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_en(serial_out_en), .block_power_enables(block_power_enables),
    .bandpass_width_select(bandpass_width_select), .center_cal_override(center_cal_override),
    .center_freq_word(center_freq_word), .center_word_active(center_word_active),
    .center_cal_start(center_cal_start), .gain_loop_source(gain_loop_source),
    .gain_loop_internal(gain_loop_internal), .gain_loop_external(gain_loop_external)
  );

  rsrp_host host (
    .core_clk(core_clk), .serial_out(serial_out), .serial_clk(serial_clk),
    .frame_select_n(frame_select_n), .serial_in(serial_in),
    .rd_valid(rd_valid), .rd_data(rd_data)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [4:0] r, input logic [15:0] v, input int n = 24);
    host.frame({a, r, v}, n);
  endtask

  // select target then clock it out; expected word noted first
  task automatic rd(input logic [4:0] r, input logic [15:0] e);
    exp_q.push_back(e);
    wr(3'h0, REG_READ_SELECT, {11'h000, r});
    en_seen = 1'b0;
    host.frame(24'h000000, 48);
    check({15'h0000, en_seen}, 16'h0001);
    check({15'h0000, serial_out_en}, 16'h0000);
  endtask

  task automatic end_of_test;
    if (mismatches == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // watcher: calibration pulses and read results
  always @(posedge core_clk)
  begin
    if (center_cal_start === 1'b1)
      cal_pulses++;
    if (serial_out_en === 1'b1)
      en_seen = 1'b1;
    if (rd_valid === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        mismatches++;
        $display("MISMATCH %0t unexpected read word", $time);
      end
      else
        check(rd_data, exp_q.pop_front());
    end
  end

  initial
  begin
    #400000;
    mismatches++;
    end_of_test;
  end

  initial
  begin
    seed = 55971;
    mismatches = 0;
    checks_done = 0;
    cal_pulses = 0;
    reset_n = 1'b0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    check(block_power_enables, RST_POWER_EN);
    check({gain_loop_internal, gain_loop_external, center_cal_override, serial_out_en, gain_loop_source,
           center_freq_word}, {4'b1010, GAIN_INTERNAL, FACTORY_CAL});
    check({6'h00, bandpass_width_select, center_word_active}, {6'h00, BW_56MHZ, FACTORY_CAL});
    d = 16'($random(seed));
    wr(3'h0, REG_POWER_EN, d);
    check(block_power_enables, d);
    wr(3'h5, REG_POWER_EN, ~d);
    check(block_power_enables, d);
    wr(3'h0, REG_POWER_EN, ~d, 23);
    check(block_power_enables, d);
    rd(REG_POWER_EN, d);
    // every width code, override on and off
    for (int b = 0; b < 4; b++)
    begin
      w = 16'($random(seed));
      wr(3'h0, REG_FILTER_CTL, {1'b1, 2'(b), 2'b00, ~b[0], 2'b01, w[7:0]});
      check({6'h00, bandpass_width_select, center_word_active},
            {6'h00, 2'(b), b[0] ? FACTORY_CAL : w[7:0]});
    end
    rd(REG_FILTER_CTL, {1'b1, 2'b11, 2'b00, 1'b0, 2'b01, w[7:0]});
    rd(REG_CAL_STATUS, {6'h00, CAL_STAT_DONE, FACTORY_CAL});
    // trigger sequence 1,1,0,1 gives two rising transitions
    cal_pulses = 0;
    wr(3'h0, REG_FILTER_CTL, RST_FILTER_CTL | 16'h0200);
    wr(3'h0, REG_FILTER_CTL, RST_FILTER_CTL | 16'h0200);
    wr(3'h0, REG_FILTER_CTL, RST_FILTER_CTL);
    wr(3'h0, REG_FILTER_CTL, RST_FILTER_CTL | 16'h0200);
    check(16'(cal_pulses), 16'h0002);
    // both gain loop sources
    for (int k = 0; k < 2; k++)
    begin
      g = (k == 0) ? GAIN_EXTERNAL : GAIN_INTERNAL;
      wr(3'h0, REG_GAIN_CTL, {g, RST_GAIN_CTL[11:0]});
      check({10'h000, gain_loop_source, gain_loop_internal, gain_loop_external},
            {10'h000, g, g == GAIN_INTERNAL, g == GAIN_EXTERNAL});
    end
    rd(REG_GAIN_CTL, {GAIN_INTERNAL, RST_GAIN_CTL[11:0]});
    // remaining writable registers, then one unmapped number
    for (int k = 0; k < 5; k++)
    begin
      d = 16'($random(seed));
      wr(3'h0, reg_list[k], d);
      rd(reg_list[k], d);
    end
    rd(5'h08, 16'h0000);
    // second reset in mid-run brings every register back
    reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    check(block_power_enables, RST_POWER_EN);
    rd(REG_FILTER_CTL, RST_FILTER_CTL);
    repeat (20) @(posedge core_clk);
    check(16'(exp_q.size()), 16'h0000);
    end_of_test;
  end
endmodule  // rsrp_port_test
`default_nettype wire
